// *** urx_recovery.sv ***
`include "urx_cfg.svh"

module urx_recovery import urx_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Configuration
    input wire logic doubleSpeedSelect,
    input wire logic [`URX_DIV_W-1:0] baudDivisor,
    input wire logic [`URX_CNT_W-1:0] frameBits,
    // Serial line
    input wire logic rxSerial,
    // Receive buffer read side
    input wire logic readStrobe,
    output logic rxValid,
    output logic [`URX_DATA_W-1:0] rxData,
    output logic frameErrorFlag,
    // Status
    output logic busy,
    output logic startValid,
    output logic noiseReject,
    output logic frameDone,
    output logic frameDropped
);

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic majority3(input logic [2:0] v);
        majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic [`URX_IDX_W-1:0] samplesPerBit(
        input logic fast
    );
        samplesPerBit = fast ? `URX_SPB_FAST : `URX_SPB_NORMAL;
    endfunction

    function automatic logic [`URX_IDX_W-1:0] firstVote(input logic fast);
        firstVote = fast ? `URX_SF_FAST : `URX_SF_NORMAL;
    endfunction

    function automatic logic [`URX_CNT_W-1:0] clampBits(
        input logic [`URX_CNT_W-1:0] b
    );
        if (b < `URX_MIN_BITS) begin
            clampBits = `URX_MIN_BITS;
        end else if (b > `URX_MAX_BITS) begin
            clampBits = `URX_MAX_BITS;
        end else begin
            clampBits = b;
        end
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        urx_state_t state;
        logic lastSample;
        logic [`URX_IDX_W-1:0] sampleIdx;
        logic [`URX_CNT_W-1:0] bitCount;
        logic [`URX_CNT_W-1:0] frameLen;
        logic [1:0] votes;
        logic [`URX_DATA_W-1:0] shiftData;
        logic fastMode;
        logic pushValid;
        urx_frame_t pushFrame;
        logic startValid;
        logic noiseReject;
    } urx_rx_state_t;

    urx_rx_state_t s;
    urx_rx_state_t next_s;

    logic sampleTick;
    logic [`URX_IDX_W-1:0] idx;
    logic [`URX_IDX_W-1:0] voteLo;
    logic [`URX_IDX_W-1:0] voteHi;
    logic inVote;
    logic decide;
    logic vote;
    urx_frame_t headFrame;

    // ************************************************************
    // Sample tick
    // ************************************************************
    urx_baud_tick u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .baudDivisor(baudDivisor),
        .sampleTick(sampleTick)
    );

    // ************************************************************
    // Sample window decode
    // ************************************************************
    always_comb begin
        // Number of the sample taken on this tick
        if (s.sampleIdx == samplesPerBit(s.fastMode)) begin
            idx = `URX_FIRST_SAMPLE;
        end else begin
            idx = s.sampleIdx + `URX_IDX_STEP;
        end
        voteLo = firstVote(s.fastMode);
        voteHi = voteLo + `URX_VOTE_SPAN;
        inVote = (idx >= voteLo) && (idx <= voteHi);
        decide = (idx == voteHi);
        vote = majority3({s.votes, rxSerial});
    end

    // ************************************************************
    // Clock and data recovery
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.pushValid = 1'b0;
        next_s.startValid = 1'b0;
        next_s.noiseReject = 1'b0;
        if (sampleTick) begin
            unique case (s.state)
                ST_IDLE: begin
                    next_s.lastSample = rxSerial;
                    if (s.lastSample && !rxSerial) begin
                        next_s.state = ST_START;
                        next_s.sampleIdx = `URX_FIRST_SAMPLE;
                        // Mode and size held for the whole frame
                        next_s.fastMode = doubleSpeedSelect;
                        next_s.frameLen = clampBits(frameBits);
                        next_s.bitCount = '0;
                        next_s.votes = '0;
                        next_s.shiftData = '0;
                    end
                end
                ST_START: begin
                    next_s.sampleIdx = idx;
                    if (inVote) begin
                        next_s.votes = {s.votes[0], rxSerial};
                    end
                    if (decide && vote) begin
                        next_s.state = ST_IDLE;
                        next_s.lastSample = rxSerial;
                        next_s.noiseReject = 1'b1;
                    end else if (decide) begin
                        // Counter stays aligned to this edge
                        next_s.startValid = 1'b1;
                    end
                    if (idx == `URX_FIRST_SAMPLE) begin
                        next_s.state = ST_BITS;
                        next_s.bitCount = '0;
                    end
                end
                ST_BITS: begin
                    next_s.sampleIdx = idx;
                    if (inVote) begin
                        next_s.votes = {s.votes[0], rxSerial};
                    end
                    if (idx == `URX_FIRST_SAMPLE) begin
                        next_s.bitCount = s.bitCount + `URX_BIT_STEP;
                    end
                    if (decide && s.bitCount < s.frameLen) begin
                        next_s.shiftData[s.bitCount] = vote;
                    end else if (decide) begin
                        // First stop bit ends the frame
                        next_s.pushValid = 1'b1;
                        next_s.pushFrame.data = s.shiftData;
                        next_s.pushFrame.frameError = !vote;
                        next_s.lastSample = rxSerial;
                        if (s.fastMode) begin
                            next_s.state = ST_REARM;
                        end else begin
                            next_s.state = ST_IDLE;
                        end
                    end
                end
                ST_REARM: begin
                    // Coarser sampling needs one more sample of margin
                    next_s.sampleIdx = idx;
                    next_s.lastSample = rxSerial;
                    if (idx == `URX_FAST_REARM) begin
                        next_s.state = ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
            s.state <= ST_IDLE;
            s.lastSample <= `URX_LINE_IDLE;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Receive buffer
    // ************************************************************
    urx_frame_buf u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .pushValid(s.pushValid),
        .pushFrame(s.pushFrame),
        .readStrobe(readStrobe),
        .rxValid(rxValid),
        .headFrame(headFrame),
        .dropPulse(frameDropped)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rxData = headFrame.data;
    assign frameErrorFlag = headFrame.frameError;
    assign busy = (s.state != ST_IDLE);
    assign startValid = s.startValid;
    assign noiseReject = s.noiseReject;
    assign frameDone = s.pushValid;

endmodule

// *** urx_cfg.svh ***
`ifndef URX_CFG_SVH
`define URX_CFG_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define URX_DATA_W 10
`define URX_DIV_W 12
`define URX_IDX_W 5
`define URX_CNT_W 4

// ****************************************************************
// Oversampling figures
// ****************************************************************
`define URX_SPB_NORMAL 5'h10
`define URX_SPB_FAST 5'h08
`define URX_SF_NORMAL 5'h08
`define URX_SF_FAST 5'h04
`define URX_VOTE_SPAN 5'h02
`define URX_FIRST_SAMPLE 5'h01
`define URX_FAST_REARM 5'h07
`define URX_IDX_STEP 5'h01

// ****************************************************************
// Frame size limits
// ****************************************************************
`define URX_MIN_BITS 4'h5
`define URX_MAX_BITS 4'ha
`define URX_BIT_STEP 4'h1

// ****************************************************************
// Reset values and counter constants
// ****************************************************************
`define URX_LINE_IDLE 1'b1
`define URX_DIV_ZERO 12'h000
`define URX_DIV_STEP 12'h001
`define URX_CNT_ZERO 2'h0
`define URX_CNT_ONE 2'h1
`define URX_CNT_FULL 2'h2

`endif

// *** urx_pkg.sv ***
`include "urx_cfg.svh"

package urx_pkg;

    // ************************************************************
    // Recovery states
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_BITS,
        ST_REARM
    } urx_state_t;

    // ************************************************************
    // One received frame with its status
    // ************************************************************
    typedef struct packed {
        logic frameError;
        logic [`URX_DATA_W-1:0] data;
    } urx_frame_t;

endpackage

// *** urx_baud_tick.sv ***
`include "urx_cfg.svh"

module urx_baud_tick import urx_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Divisor
    input wire logic [`URX_DIV_W-1:0] baudDivisor,
    // Sample strobe
    output logic sampleTick
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [`URX_DIV_W-1:0] count;
        logic tick;
    } urx_tick_state_t;

    urx_tick_state_t s;
    urx_tick_state_t next_s;

    // Period is divisor plus one clocks; a live divisor change
    // takes effect at the next reload only
    always_comb begin
        next_s = s;
        if (s.count == `URX_DIV_ZERO) begin
            next_s.count = baudDivisor;
            next_s.tick = 1'b1;
        end else begin
            next_s.count = s.count - `URX_DIV_STEP;
            next_s.tick = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    assign sampleTick = s.tick & clkEn;

endmodule

// *** urx_frame_buf.sv ***
`include "urx_cfg.svh"

module urx_frame_buf import urx_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Fill side
    input wire logic pushValid,
    input wire urx_frame_t pushFrame,
    // Read side
    input wire logic readStrobe,
    output logic rxValid,
    output urx_frame_t headFrame,
    output logic dropPulse
);

    // ************************************************************
    // State: head slot drives headFrame directly
    // ************************************************************
    typedef struct packed {
        urx_frame_t [1:0] slot;
        logic [1:0] count;
        logic drop;
    } urx_buf_state_t;

    urx_buf_state_t s;
    urx_buf_state_t next_s;
    logic [1:0] left;

    // Pop before push, so a full buffer read in the same cycle
    // still takes the new frame
    always_comb begin
        next_s = s;
        next_s.drop = 1'b0;
        left = s.count;
        if (readStrobe && s.count != `URX_CNT_ZERO) begin
            next_s.slot[0] = s.slot[1];
            left = s.count - `URX_CNT_ONE;
        end
        next_s.count = left;
        if (pushValid) begin
            if (left == `URX_CNT_ZERO) begin
                next_s.slot[0] = pushFrame;
                next_s.count = `URX_CNT_ONE;
            end else if (left == `URX_CNT_ONE) begin
                next_s.slot[1] = pushFrame;
                next_s.count = `URX_CNT_FULL;
            end else begin
                next_s.drop = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    assign rxValid = (s.count != `URX_CNT_ZERO);
    assign headFrame = s.slot[0];
    assign dropPulse = s.drop;

endmodule

// *** urx_recovery_asserts.sv ***
`include "urx_cfg.svh"

module urx_recovery_asserts import urx_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Read side
    input wire logic readStrobe,
    input wire logic rxValid,
    input wire logic [`URX_DATA_W-1:0] rxData,
    input wire logic frameErrorFlag,
    // Status
    input wire logic busy,
    input wire logic startValid,
    input wire logic noiseReject,
    input wire logic frameDone,
    input wire logic frameDropped
);
    // ****
    // Checks
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_reset_clear: assert property ($fell(sys_rst) |-> !busy && !rxValid)
        else $error("state left after reset");
    a_start_late: assert property ($rose(busy) |->
        (!startValid && !noiseReject) [*8])
        else $error("start judged too early");
    a_pulse_excl: assert property (!(startValid && noiseReject))
        else $error("start both taken and rejected");
    a_start_once: assert property (startValid |=> (!startValid) [*8])
        else $error("start pulse repeated");
    a_start_busy: assert property (startValid |-> busy)
        else $error("recovery not running after start");
    a_done_gap: assert property (frameDone |=> (!frameDone) [*8])
        else $error("frame done repeated");
    a_done_valid: assert property (frameDone |=> rxValid)
        else $error("finished frame not buffered");
    a_hold_head: assert property (rxValid && !readStrobe |=>
        $stable(rxData) && $stable(frameErrorFlag))
        else $error("head frame changed without read");
    a_drop_full: assert property (frameDropped |-> rxValid)
        else $error("drop with room in buffer");
endmodule

bind urx_recovery urx_recovery_asserts u_urx_recovery_asserts (
    .clk(clk),
    .sys_rst(sys_rst),
    .readStrobe(readStrobe),
    .rxValid(rxValid),
    .rxData(rxData),
    .frameErrorFlag(frameErrorFlag),
    .busy(busy),
    .startValid(startValid),
    .noiseReject(noiseReject),
    .frameDone(frameDone),
    .frameDropped(frameDropped)
);

// *** urx_line_model.sv ***
module urx_line_model (
    // Clock
    input wire logic clk,
    // Serial line, idle high
    output logic txLine
);
    timeunit 1ns;
    timeprecision 1ns;

    initial txLine = 1'b1;

    task automatic hold(input logic v, input int n);
        txLine = v;
        repeat (n) @(negedge clk);
    endtask

    // Rate free per call, so a mismatched sender can be played
    task automatic send(input logic [9:0] d, input int n, input int bc,
        input logic stopV, input int stopClk, input int glitch);
        hold(1'b0, bc);
        for (int k = 0; k < n; k++) begin
            if (k == glitch) begin
                hold(d[k], bc / 2);
                hold(!d[k], 2);
                hold(d[k], bc - bc / 2 - 2);
            end else begin
                hold(d[k], bc);
            end
        end
        hold(stopV, stopClk);
        txLine = 1'b1;
    endtask
endmodule

// *** test_urx_recovery.sv ***
`include "urx_cfg.svh"

module test_urx_recovery;
    timeunit 1ns;
    timeprecision 1ns;

    // ****
    // Signals
    // ****
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic doubleSpeedSelect = 1'b0;
    logic [`URX_DIV_W-1:0] baudDivisor = 12'h001;
    logic [`URX_CNT_W-1:0] frameBits = 4'h8;
    logic readStrobe = 1'b0;
    logic rxSerial, rxValid, frameErrorFlag, busy;
    logic startValid, noiseReject, frameDone, frameDropped;
    logic [`URX_DATA_W-1:0] rxData;
    int error_cnt = 0;
    int comparisons = 0;
    int starts = 0;
    int rejects = 0;
    int drops = 0;
    int dones = 0;

    always #5 clk = ~clk;

    // Pulses counted mid-cycle, clear of the edge
    always @(negedge clk) begin
        starts += startValid;
        rejects += noiseReject;
        drops += frameDropped;
        dones += frameDone;
    end

    urx_line_model u_urx_line_model (.clk(clk), .txLine(rxSerial));

    urx_recovery u_urx_recovery (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .doubleSpeedSelect(doubleSpeedSelect),
        .baudDivisor(baudDivisor),
        .frameBits(frameBits),
        .rxSerial(rxSerial),
        .readStrobe(readStrobe),
        .rxValid(rxValid),
        .rxData(rxData),
        .frameErrorFlag(frameErrorFlag),
        .busy(busy),
        .startValid(startValid),
        .noiseReject(noiseReject),
        .frameDone(frameDone),
        .frameDropped(frameDropped)
    );

    // ****
    // Scenarios
    // ****
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic pop(input logic [9:0] d, input logic fe);
        int n = 0;
        while (rxValid !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check({9'h0, rxValid}, 10'h001);
        check(rxData, d);
        check({9'h0, frameErrorFlag}, {9'h0, fe});
        readStrobe = 1'b1;
        @(negedge clk);
        readStrobe = 1'b0;
        // One idle cycle so back-to-back reads never retoggle the strobe
        @(negedge clk);
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check({7'h0, busy, rxValid, frameErrorFlag}, 10'h000);
    endtask

    task automatic t_modes();
        for (int m = 0; m < 2; m++) begin
            doubleSpeedSelect = m[0];
            frameBits = m ? 4'ha : 4'h8;
            u_urx_line_model.send(10'h3a5, m ? 10 : 8, m ? 16 : 32,
                1'b1, m ? 16 : 32, 2);
            pop(m ? 10'h3a5 : 10'h0a5, 1'b0);
            frameBits = 4'h5;
            u_urx_line_model.send(10'h015, 5, m ? 16 : 32, 1'b0,
                m ? 16 : 32, -1);
            pop(10'h015, 1'b1);
            // Break leaves no idle; give the edge detector a high sample
            u_urx_line_model.hold(1'b1, 32);
        end
    endtask

    // Low for exactly the first vote sample, then one sample more
    task automatic t_noise();
        int r;
        int s;
        frameBits = 4'h5;
        for (int m = 0; m < 2; m++) begin
            doubleSpeedSelect = m[0];
            r = rejects;
            s = starts;
            u_urx_line_model.hold(1'b0, m ? 8 : 16);
            u_urx_line_model.hold(1'b1, 64);
            check(10'(rejects - r), 10'h001);
            check(10'(starts - s), 10'h000);
            u_urx_line_model.hold(1'b0, m ? 10 : 18);
            u_urx_line_model.hold(1'b1, 8);
            pop(10'h01f, 1'b0);
            check(10'(starts - s), 10'h001);
        end
    endtask

    // Shortest stop bits, three frames, no reads: third one lost
    task automatic t_burst();
        int dr;
        int dn;
        frameBits = 4'h8;
        for (int m = 0; m < 2; m++) begin
            doubleSpeedSelect = m[0];
            dr = drops;
            dn = dones;
            for (int f = 1; f < 4; f++)
                u_urx_line_model.send(10'(f * 17), 8, m ? 16 : 32,
                    1'b1, m ? 14 : 20, -1);
            u_urx_line_model.hold(1'b1, 80);
            check(10'(drops - dr), 10'h001);
            check(10'(dones - dn), 10'h003);
            pop(10'h011, 1'b0);
            pop(10'h022, 1'b0);
            check({9'h0, rxValid}, 10'h000);
        end
    endtask

    // Sender about 3 percent fast and slow, inside the tolerated band
    task automatic t_rate();
        int m;
        int bc;
        for (int i = 0; i < 4; i++) begin
            m = i / 2;
            bc = (i % 2) ? 66 : 62;
            doubleSpeedSelect = m[0];
            baudDivisor = m ? 12'h007 : 12'h003;
            frameBits = m ? 4'h5 : 4'ha;
            u_urx_line_model.send(10'h2d6, m ? 5 : 10, bc, 1'b1, bc, -1);
            pop(m ? 10'h016 : 10'h2d6, 1'b0);
        end
        baudDivisor = 12'h001;
    endtask

    // Frozen enable keeps the buffer; reset mid-frame clears everything
    task automatic t_reset();
        doubleSpeedSelect = 1'b0;
        frameBits = 4'h8;
        u_urx_line_model.send(10'h0c3, 8, 32, 1'b1, 32, -1);
        clkEn = 1'b0;
        readStrobe = 1'b1;
        @(negedge clk);
        readStrobe = 1'b0;
        @(negedge clk);
        check({9'h0, rxValid}, 10'h001);
        check(rxData, 10'h0c3);
        clkEn = 1'b1;
        u_urx_line_model.hold(1'b0, 20);
        check({8'h0, busy, rxValid}, 10'h003);
        u_urx_line_model.hold(1'b1, 1);
        do_reset();
        frameBits = 4'hf;
        u_urx_line_model.send(10'h35a, 10, 32, 1'b1, 32, -1);
        pop(10'h35a, 1'b0);
    endtask

    // ****
    // Run
    // ****
    initial begin
        do_reset();
        t_modes();
        t_noise();
        t_burst();
        t_rate();
        t_reset();
        final_report();
    end

    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
endmodule
